// ===== logic/ifm_mapper.sv
// Input terminal function mapper with output cutoff and AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
module ifm_mapper import ifm_pkg::*; #(
	parameter int SLOW_CYC = TICK_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [ADDR_W-1:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [ADDR_W-1:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [NTERM-1:0] term_in,
	input wire logic motor_running,
	output logic low_speed_cmd,
	output logic mid_speed_cmd,
	output logic high_speed_cmd,
	output logic remote_clear,
	output logic remote_decel,
	output logic remote_accel,
	output logic speed_ext_select,
	output logic second_set_select,
	output logic alt_analog_select,
	output logic analog_v_enable,
	output logic jog_select,
	output logic ext_thermal_trip,
	output logic pid_enable,
	output logic vf_control,
	output logic panel_net_switch,
	output logic ext_net_switch,
	output logic drive_reset,
	output logic [1:0] speed_src,
	output logic run_permit,
	output logic panel_interlock,
	output logic output_cutoff,
	output logic fwd_run,
	output logic rev_run,
	output logic coast_stop,
	output logic decel_stop
);
	typedef struct packed {
		logic [NTERM-1:0] sync1;
		logic [NTERM-1:0] sync2;
		logic [NTERM-1:0][SEL_W-1:0] sel;
		logic [7:0] remote;
		logic [2:0] cut_sel;
		logic [3:0] mode;
		logic comm_cut;
		logic [CNT_W-1:0] cnt;
		logic tick;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] awaddr;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic awready;
		logic wready;
		logic bvalid;
		logic [1:0] bresp;
		logic arready;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
		logic [20:0] slow;
		logic [1:0] src;
		logic permit;
		logic ilock;
		logic cut;
		logic fwd;
		logic rev;
		logic coast;
		logic decel;
	} ifm_state_t;

	ifm_state_t s;
	ifm_state_t next_s;

	// Legal select code for a given terminal
	function automatic logic code_ok(input int idx, input logic [SEL_W-1:0] c);
		logic ok;
		ok = 1'b0;
		case (c)
			FN_LOW, FN_MID, FN_HIGH, FN_SECOND, FN_ALT_AN, FN_JOG, FN_THERM,
			FN_EXT, FN_PERMIT, FN_ILOCK, FN_PID, FN_PU_EXT, FN_VF, FN_CUT,
			FN_HOLD, FN_TRAV, FN_RESET, FN_PANEL, FN_NET, FN_SRC, FN_NONE: ok = 1'b1;
			FN_FWD: ok = (idx == 0);
			FN_REV: ok = (idx == 1);
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : code_ok

	// OR of every terminal carrying one code; inv reads open contact as on
	function automatic logic fn_or(input ifm_state_t st, input logic [SEL_W-1:0] c, input logic inv);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NTERM; i++) begin
			if (st.sel[i] == c) begin
				r = r | (st.sync2[i] ^ inv);
			end
		end
		return r;
	endfunction : fn_or

	function automatic logic fn_used(input ifm_state_t st, input logic [SEL_W-1:0] c);
		logic r;
		r = 1'b0;
		for (int i = 0; i < NTERM; i++) begin
			r = r | (st.sel[i] == c);
		end
		return r;
	endfunction : fn_used

	// Byte-lane merge of a write
	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (st[b]) begin
				r[8*b +: 8] = d[8*b +: 8];
			end
		end
		return r;
	endfunction : merge

	logic shut_c;
	logic term_cut_c;
	logic therm_c;
	logic [31:0] cfg_rd;
	logic [31:0] stat_rd;
	logic [20:0] slow_c;

	assign cfg_rd = {15'h0000, s.comm_cut, s.mode, 1'b0, s.cut_sel, s.remote};
	assign stat_rd = {s.coast, s.decel, s.fwd, s.rev, s.cut, s.ilock, s.permit, s.src, 2'h0, s.slow};

	always_comb begin
		logic speed_any;
		logic rt;
		logic ext_on;
		logic [31:0] cur;
		logic [31:0] nv;
		int widx;
		logic hit;
		speed_any = 1'b0;
		rt = 1'b0;
		ext_on = 1'b0;
		cur = 32'h0000_0000;
		nv = 32'h0000_0000;
		widx = 0;
		hit = 1'b0;
		next_s = s;
		// Two-stage synchroniser on the contacts
		next_s.sync1 = term_in;
		next_s.sync2 = s.sync1;

		// Divider: slow functions refresh once per tick
		next_s.tick = 1'b0;
		if (s.cnt >= CNT_W'(SLOW_CYC - 1)) begin
			next_s.cnt = '0;
			next_s.tick = 1'b1;
		end else begin
			next_s.cnt = s.cnt + CNT_W'(1);
		end

		// Cutoff contact logic; unknown selections act as normally open
		term_cut_c = fn_or(s, FN_CUT, 1'b0);
		case (s.cut_sel)
			CUT_NC: shut_c = !(term_cut_c && s.comm_cut);
			CUT_MIX: shut_c = !(term_cut_c && !s.comm_cut);
			default: shut_c = term_cut_c || s.comm_cut;
		endcase
		// Thermal relay trips on an open contact
		therm_c = fn_or(s, FN_THERM, 1'b1);

		// Same shared terminals serve presets or remote setting
		ext_on = fn_or(s, FN_EXT, 1'b0);
		slow_c[0] = (s.remote == 8'h00) && fn_or(s, FN_LOW, 1'b0);
		slow_c[1] = (s.remote == 8'h00) && fn_or(s, FN_MID, 1'b0);
		slow_c[2] = (s.remote == 8'h00) && fn_or(s, FN_HIGH, 1'b0);
		slow_c[3] = (s.remote != 8'h00) && fn_or(s, FN_LOW, 1'b0);
		slow_c[4] = (s.remote != 8'h00) && fn_or(s, FN_MID, 1'b0);
		slow_c[5] = (s.remote != 8'h00) && fn_or(s, FN_HIGH, 1'b0);
		slow_c[6] = ext_on;
		// Control method only switches while stopped
		slow_c[13] = motor_running ? s.slow[13] : fn_or(s, FN_VF, 1'b0);
		// V/F request always brings the second set
		rt = fn_or(s, FN_SECOND, 1'b0) || fn_or(s, FN_VF, 1'b0);
		slow_c[7] = rt;
		slow_c[8] = fn_or(s, FN_ALT_AN, 1'b0);
		slow_c[9] = !slow_c[8];
		slow_c[10] = fn_or(s, FN_JOG, 1'b0);
		slow_c[11] = therm_c;
		slow_c[12] = fn_or(s, FN_PID, 1'b0);
		slow_c[14] = fn_or(s, FN_PANEL, 1'b0);
		slow_c[15] = fn_or(s, FN_NET, 1'b0);
		slow_c[16] = fn_or(s, FN_RESET, 1'b0);
		slow_c[20:17] = 4'h0;
		speed_any = slow_c[0] || slow_c[1] || slow_c[2] || ext_on;
		if (s.tick) begin
			next_s.slow = slow_c;
			// Inching beats presets beats PID
			if (slow_c[10]) begin
				next_s.src = IFM_SRC_JOG;
			end else if (speed_any) begin
				next_s.src = IFM_SRC_PRESET;
			end else if (slow_c[12]) begin
				next_s.src = IFM_SRC_PID;
			end else begin
				next_s.src = IFM_SRC_NONE;
			end
		end

		// Fast path, refreshed every cycle
		next_s.cut = shut_c;
		// Cutoff stands in for an unassigned permit, and for an unassigned interlock in MODE_ILOCK
		next_s.permit = fn_used(s, FN_PERMIT) ? fn_or(s, FN_PERMIT, 1'b0) : !shut_c;
		if (fn_used(s, FN_ILOCK)) begin
			next_s.ilock = fn_or(s, FN_ILOCK, 1'b0);
		end else begin
			next_s.ilock = (s.mode == MODE_ILOCK) && shut_c;
		end
		// Start is refused under cutoff
		next_s.fwd = fn_or(s, FN_FWD, 1'b0) && !shut_c && next_s.permit;
		next_s.rev = fn_or(s, FN_REV, 1'b0) && !shut_c && next_s.permit;
		// Cutoff coasts; a plain stop ramps down
		next_s.coast = shut_c;
		next_s.decel = !shut_c && motor_running && !next_s.fwd && !next_s.rev;

		// Write channel: address and data taken in either order
		if (s_axi_awvalid && s.awready) begin
			next_s.aw_got = 1'b1;
			next_s.awaddr = s_axi_awaddr;
			next_s.awready = 1'b0;
		end
		if (s_axi_wvalid && s.wready) begin
			next_s.w_got = 1'b1;
			next_s.wdata = s_axi_wdata;
			next_s.wstrb = s_axi_wstrb;
			next_s.wready = 1'b0;
		end
		if (s.aw_got && s.w_got && !s.bvalid) begin
			next_s.bvalid = 1'b1;
			next_s.bresp = RESP_SLVERR;
			widx = int'(s.awaddr[ADDR_W-1:2]);
			if (s.awaddr == OFS_CFG) begin
				nv = merge(cfg_rd, s.wdata, s.wstrb);
				next_s.remote = nv[CFG_REM_LSB +: 8];
				next_s.cut_sel = nv[CFG_CUT_LSB +: 3];
				next_s.mode = nv[CFG_MODE_LSB +: 4];
				next_s.comm_cut = nv[CFG_COMM_BIT];
				next_s.bresp = RESP_OKAY;
			end else if (s.awaddr[1:0] == 2'b00 && widx < NTERM) begin
				hit = 1'b1;
			end
			if (hit) begin
				cur = {18'h0_0000, s.sel[widx]};
				nv = merge(cur, s.wdata, s.wstrb);
				// Illegal codes leave the selector unchanged
				if (nv[31:SEL_W] == '0 && code_ok(widx, nv[SEL_W-1:0])) begin
					next_s.sel[widx] = nv[SEL_W-1:0];
					next_s.bresp = RESP_OKAY;
				end
			end
		end
		if (s.bvalid && s_axi_bready) begin
			next_s.bvalid = 1'b0;
			next_s.aw_got = 1'b0;
			next_s.w_got = 1'b0;
			next_s.awready = 1'b1;
			next_s.wready = 1'b1;
		end

		// Read channel, one beat answered the cycle after the address
		if (s_axi_arvalid && s.arready) begin
			next_s.arready = 1'b0;
			next_s.rvalid = 1'b1;
			next_s.rresp = RESP_OKAY;
			next_s.rdata = 32'h0000_0000;
			case (s_axi_araddr)
				OFS_CFG: next_s.rdata = cfg_rd;
				OFS_STAT: next_s.rdata = stat_rd;
				OFS_TERM: next_s.rdata = {27'h000_0000, s.sync2};
				default: begin
					widx = int'(s_axi_araddr[ADDR_W-1:2]);
					if (s_axi_araddr[1:0] == 2'b00 && widx < NTERM) begin
						next_s.rdata = {18'h0_0000, s.sel[widx]};
					end else begin
						next_s.rresp = RESP_SLVERR;
					end
				end
			endcase
		end
		if (s.rvalid && s_axi_rready) begin
			next_s.rvalid = 1'b0;
			next_s.arready = 1'b1;
		end
	end

	// State register; selectors start at their shipped assignments
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s <= '0;
			s.sel[0] <= FN_FWD;
			s.sel[1] <= FN_REV;
			s.sel[2] <= FN_LOW;
			s.sel[3] <= FN_MID;
			s.sel[4] <= FN_HIGH;
			s.awready <= 1'b1;
			s.wready <= 1'b1;
			s.arready <= 1'b1;
			s.slow[9] <= 1'b1;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_awready = s.awready;
	assign s_axi_wready = s.wready;
	assign s_axi_bvalid = s.bvalid;
	assign s_axi_bresp = s.bresp;
	assign s_axi_arready = s.arready;
	assign s_axi_rvalid = s.rvalid;
	assign s_axi_rdata = s.rdata;
	assign s_axi_rresp = s.rresp;
	assign low_speed_cmd = s.slow[0];
	assign mid_speed_cmd = s.slow[1];
	assign high_speed_cmd = s.slow[2];
	assign remote_clear = s.slow[3];
	assign remote_decel = s.slow[4];
	assign remote_accel = s.slow[5];
	assign speed_ext_select = s.slow[6];
	assign second_set_select = s.slow[7];
	assign alt_analog_select = s.slow[8];
	assign analog_v_enable = s.slow[9];
	assign jog_select = s.slow[10];
	assign ext_thermal_trip = s.slow[11];
	assign pid_enable = s.slow[12];
	assign vf_control = s.slow[13];
	assign panel_net_switch = s.slow[14];
	assign ext_net_switch = s.slow[15];
	assign drive_reset = s.slow[16];
	assign speed_src = s.src;
	assign run_permit = s.permit;
	assign panel_interlock = s.ilock;
	assign output_cutoff = s.cut;
	assign fwd_run = s.fwd;
	assign rev_run = s.rev;
	assign coast_stop = s.coast;
	assign decel_stop = s.decel;

	// Checks on the mapped outputs and the selectors
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	AST_CUT_COAST: assert property (output_cutoff |-> coast_stop && !decel_stop)
		else $error("cutoff without coasting");
	AST_NO_START: assert property (output_cutoff |-> !fwd_run && !rev_run)
		else $error("start accepted under cutoff");
	AST_FAST: assert property (shut_c |=> output_cutoff)
		else $error("cutoff late");
	AST_SLOW: assert property ($changed(pid_enable) |-> $past(s.tick))
		else $error("slow output moved off tick");
	AST_VF_HOLD: assert property (motor_running && $past(motor_running) |-> $stable(vf_control))
		else $error("control method changed while running");
	AST_ANALOG: assert property (analog_v_enable != alt_analog_select)
		else $error("voltage input not disabled");
	AST_SEL_REJ: assert property (s.sel[0] != FN_REV && s.sel[1] != FN_FWD && s.sel[2] != FN_FWD)
		else $error("start code on wrong terminal");
	AST_THERM: assert property (s.tick && therm_c |=> ext_thermal_trip)
		else $error("thermal trip missed");
	AST_PRIO: assert property (jog_select |-> speed_src == IFM_SRC_JOG)
		else $error("jog not first");
	AST_MIX: assert property (s.cut_sel == CUT_MIX && term_cut_c && s.comm_cut |=> output_cutoff)
		else $error("mixed logic did not shut off");

	COV_CUT: cover property (fwd_run ##1 output_cutoff);
	COV_WR: cover property (s_axi_bvalid && s_axi_bready && s_axi_bresp == RESP_OKAY);
	COV_RD: cover property (s_axi_rvalid && s_axi_rready);
endmodule : ifm_mapper
`default_nettype wire

// ===== logic/ifm_pkg.sv
// Constants, codes and register map of the input function mapper
// Overview of operation
// - Codes 0-2: speed steps, or remote when selected
// - Code 8: speed extension, fifteen presets
// - Code 10 run permit, 12 panel interlock
// - Code 14 enables PID while asserted
// - Code 24 on any terminal: output cutoff
// - Codes 65/66 select panel or network operation
// - Same code on several terminals ORs inputs
// - Speed priority: inching, presets, then PID
// - Cutoff covers missing permit or interlock; interlock only in mode 7 (MODE_ILOCK)
// - Presets and remote share terminals, not separable
// - V/F selects second set; frozen while running
// - Alternate analog select disables voltage input
// - Permit and cutoff act within 2 ms
// - Other functions act within 20 ms
// - Thermal trip active on open contact
// - Cutoff while running coasts immediately
// - Cutoff active refuses any start
// - Start removed decelerates; cutoff coasts
// - Cutoff logic 0 NO, 2 NC, 4 mixed
// - Logic 2: open contact shuts output
// - Code 3 applies second parameter set
// - Logic 4: run only terminal on, comm off
package ifm_pkg;
	localparam int NTERM = 5;
	localparam int SEL_W = 14;
	localparam int ADDR_W = 8;
	// Select codes
	localparam logic [13:0] FN_LOW = 14'h0000;
	localparam logic [13:0] FN_MID = 14'h0001;
	localparam logic [13:0] FN_HIGH = 14'h0002;
	localparam logic [13:0] FN_SECOND = 14'h0003;
	localparam logic [13:0] FN_ALT_AN = 14'h0004;
	localparam logic [13:0] FN_JOG = 14'h0005;
	localparam logic [13:0] FN_THERM = 14'h0007;
	localparam logic [13:0] FN_EXT = 14'h0008;
	localparam logic [13:0] FN_PERMIT = 14'h000A;
	localparam logic [13:0] FN_ILOCK = 14'h000C;
	localparam logic [13:0] FN_PID = 14'h000E;
	localparam logic [13:0] FN_PU_EXT = 14'h0010;
	localparam logic [13:0] FN_VF = 14'h0012;
	localparam logic [13:0] FN_CUT = 14'h0018;
	localparam logic [13:0] FN_HOLD = 14'h0019;
	localparam logic [13:0] FN_TRAV = 14'h0025;
	localparam logic [13:0] FN_FWD = 14'h003C;
	localparam logic [13:0] FN_REV = 14'h003D;
	localparam logic [13:0] FN_RESET = 14'h003E;
	localparam logic [13:0] FN_PANEL = 14'h0041;
	localparam logic [13:0] FN_NET = 14'h0042;
	localparam logic [13:0] FN_SRC = 14'h0043;
	localparam logic [13:0] FN_NONE = 14'h270F;
	// Cutoff logic selections and interlock mode
	localparam logic [2:0] CUT_NO = 3'h0;
	localparam logic [2:0] CUT_NC = 3'h2;
	localparam logic [2:0] CUT_MIX = 3'h4;
	localparam logic [3:0] MODE_ILOCK = 4'h7;
	// Register byte offsets
	localparam logic [7:0] OFS_SEL0 = 8'h00;
	localparam logic [7:0] OFS_CFG = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;
	localparam logic [7:0] OFS_TERM = 8'h1C;
	// Config field positions
	localparam int CFG_REM_LSB = 0;
	localparam int CFG_CUT_LSB = 8;
	localparam int CFG_MODE_LSB = 12;
	localparam int CFG_COMM_BIT = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Speed source encoding
	typedef enum logic [1:0] {
		IFM_SRC_NONE = 2'b00,
		IFM_SRC_JOG = 2'b01,
		IFM_SRC_PRESET = 2'b10,
		IFM_SRC_PID = 2'b11
	} ifm_src_t;
	// Timing: slow functions refresh every tick
	localparam int CLK_NS = 25;
	localparam int TICK_NS = 1_000_000;
	localparam int TICK_CYC = TICK_NS / CLK_NS;
	localparam int CNT_W = 16;
endpackage : ifm_pkg

// ===== verif/ifm_contacts.sv
// Model of the external switch contacts wired to the terminals
`timescale 1ns/10ps
`default_nettype none
module ifm_contacts (
	input wire logic aclk,
	input wire logic [4:0] want,
	input wire logic slow,
	output logic [4:0] term_in
);
	logic [4:0] d1;
	logic [4:0] d2;
	// Relay travel: slow contacts settle two cycles late
	always_ff @(posedge aclk) begin
		d1 <= want;
		d2 <= d1;
	end
	// Prompt contacts follow at once
	assign term_in = slow ? d2 : want;
endmodule : ifm_contacts
`default_nettype wire

// ===== verif/tb.sv
// Self-checking testbench of the input function mapper
`timescale 1ns/10ps
`default_nettype none
module tb import ifm_pkg::*;;
	logic aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
	logic motor_running, slow, s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [7:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata;
	logic [3:0] s_axi_wstrb;
	logic [4:0] want, term_in;
	logic [1:0] s_axi_bresp, s_axi_rresp, speed_src;
	logic low_speed_cmd, mid_speed_cmd, high_speed_cmd, remote_clear, remote_decel, remote_accel;
	logic speed_ext_select, second_set_select, alt_analog_select, analog_v_enable, jog_select;
	logic ext_thermal_trip, pid_enable, vf_control, panel_net_switch, ext_net_switch, drive_reset;
	logic run_permit, panel_interlock, output_cutoff, fwd_run, rev_run, coast_stop, decel_stop;
	int n_mismatch, checks_done;
	// Short tick keeps slow functions quick in simulation
	ifm_mapper #(.SLOW_CYC(8)) i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
		.s_axi_rvalid, .s_axi_rready, .term_in, .motor_running, .low_speed_cmd, .mid_speed_cmd,
		.high_speed_cmd, .remote_clear, .remote_decel, .remote_accel, .speed_ext_select,
		.second_set_select, .alt_analog_select, .analog_v_enable, .jog_select, .ext_thermal_trip,
		.pid_enable, .vf_control, .panel_net_switch, .ext_net_switch, .drive_reset, .speed_src,
		.run_permit, .panel_interlock, .output_cutoff, .fwd_run, .rev_run, .coast_stop, .decel_stop);
	ifm_contacts i_contacts (.aclk, .want, .slow, .term_in);
	// Clock at 40 MHz
	initial begin
		aclk = 1'b0;
		forever #12.5 aclk = ~aclk;
	end
	task automatic finish_test;
		$display("checks %0d mismatches %0d", checks_done, n_mismatch);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : finish_test
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task automatic wt(input int n);
		repeat (n) @(posedge aclk);
	endtask : wt
	// Write: address and data offered together, each dropped when taken
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		logic ta, tw;
		ta = 1'b0;
		tw = 1'b0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_awready && !ta) begin
				ta = 1'b1;
				s_axi_awvalid <= 1'b0;
			end
			if (s_axi_wready && !tw) begin
				tw = 1'b1;
				s_axi_wvalid <= 1'b0;
			end
		end while (!(s_axi_bvalid && ta && tw));
		r = s_axi_bresp;
	endtask : axw
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		logic t;
		t = 1'b0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			if (s_axi_arready && !t) begin
				t = 1'b1;
				s_axi_arvalid <= 1'b0;
			end
		end while (!(s_axi_rvalid && t));
		d = s_axi_rdata;
		r = s_axi_rresp;
	endtask : axr
	task automatic ws(input logic [7:0] a, input logic [31:0] d);
		logic [1:0] r;
		axw(a, d, r);
		chk("bresp", 32'(r), 32'(RESP_OKAY));
	endtask : ws
	task automatic sel3(input logic [13:0] a, input logic [13:0] b, input logic [13:0] c);
		ws(8'h08, 32'(a));
		ws(8'h0C, 32'(b));
		ws(8'h10, 32'(c));
	endtask : sel3
	task automatic cfg(input logic [7:0] rem, input logic [2:0] cut, input logic [3:0] mode, input logic comm);
		ws(OFS_CFG, {15'h0000, comm, mode, 1'b0, cut, rem});
	endtask : cfg
	// Output that a select code drives
	function automatic logic pick(input logic [13:0] c);
		case (c)
			FN_THERM: pick = ext_thermal_trip;
			FN_SECOND: pick = second_set_select;
			FN_ALT_AN: pick = alt_analog_select;
			FN_PID: pick = pid_enable;
			FN_PANEL: pick = panel_net_switch;
			FN_NET: pick = ext_net_switch;
			FN_ILOCK: pick = panel_interlock;
			FN_PERMIT: pick = run_permit;
			FN_VF: pick = vf_control;
			FN_EXT: pick = speed_ext_select;
			FN_JOG: pick = jog_select;
			default: pick = drive_reset;
		endcase
	endfunction : pick
	task automatic t_reset;
		logic [31:0] d;
		logic [1:0] r;
		logic [13:0] rv [5];
		rv = '{FN_FWD, FN_REV, FN_LOW, FN_MID, FN_HIGH};
		for (int i = 0; i < 5; i++) begin
			axr(8'(4 * i), d, r);
			chk("selector", d, 32'(rv[i]));
		end
		axr(OFS_CFG, d, r);
		chk("cfg", d, 32'h0000_0000);
		// Idle status: cutoff stands in for permit, voltage input enabled
		axr(OFS_STAT, d, r);
		chk("status", d, 32'h0200_0200);
		axr(8'h40, d, r);
		chk("unmapped", 32'(r), 32'(RESP_SLVERR));
		axw(8'h04, 32'(FN_FWD), r);
		chk("fwd on sel1", 32'(r), 32'(RESP_SLVERR));
		axw(OFS_SEL0, 32'(FN_REV), r);
		chk("rev on sel0", 32'(r), 32'(RESP_SLVERR));
		axw(8'h04, 32'(FN_REV), r);
		chk("rev on sel1", 32'(r), 32'(RESP_OKAY));
	endtask : t_reset
	task automatic t_codes;
		logic [31:0] d;
		logic [1:0] r;
		logic [13:0] c;
		logic [13:0] tab [12];
		tab = '{FN_THERM, FN_SECOND, FN_ALT_AN, FN_PID, FN_PANEL, FN_NET, FN_ILOCK, FN_PERMIT, FN_VF,
			FN_EXT, FN_JOG, FN_RESET};
		for (int i = 0; i < 12; i++) begin
			c = tab[i];
			sel3(c, FN_MID, FN_HIGH);
			want <= 5'h04;
			wt(14);
			chk("closed", 32'(pick(c)), 32'(c != FN_THERM));
			chk("voltage in", 32'(analog_v_enable), 32'(c != FN_ALT_AN));
			axr(OFS_TERM, d, r);
			chk("terminals", d, 32'h0000_0004);
			want <= 5'h00;
			wt(14);
			chk("open", 32'(pick(c)), 32'(c == FN_THERM));
		end
	endtask : t_codes
	task automatic t_speed;
		sel3(FN_LOW, FN_MID, FN_HIGH);
		for (int r = 0; r < 2; r++) begin
			cfg(8'(r), CUT_NO, 4'h0, 1'b0);
			for (int i = 0; i < 3; i++) begin
				want <= 5'(4 << i);
				wt(14);
				chk("steps", {29'h0000_0000, high_speed_cmd, mid_speed_cmd, low_speed_cmd},
					(r == 0) ? 32'(1 << i) : 32'h0000_0000);
				chk("remote", {29'h0000_0000, remote_accel, remote_decel, remote_clear},
					(r == 0) ? 32'h0000_0000 : 32'(1 << i));
			end
		end
		cfg(8'h00, CUT_NO, 4'h0, 1'b0);
	endtask : t_speed
	task automatic t_prio;
		sel3(FN_JOG, FN_LOW, FN_PID);
		want <= 5'h1C;
		wt(14);
		chk("src", 32'(speed_src), 32'(IFM_SRC_JOG));
		want <= 5'h18;
		wt(14);
		chk("src", 32'(speed_src), 32'(IFM_SRC_PRESET));
		want <= 5'h10;
		wt(14);
		chk("src", 32'(speed_src), 32'(IFM_SRC_PID));
		sel3(FN_PID, FN_MID, FN_PID);
		for (int i = 0; i < 4; i++) begin
			want <= {i[1], 1'b0, i[0], 2'b00};
			wt(14);
			chk("pid or", 32'(pid_enable), 32'(i != 0));
		end
	endtask : t_prio
	task automatic t_cut;
		logic e;
		sel3(FN_MID, FN_HIGH, FN_CUT);
		for (int k = 0; k < 12; k++) begin
			cfg(8'h00, 3'(2 * (k / 4)), MODE_ILOCK, k[0]);
			want <= {k[1], 4'h0};
			wt(6);
			case (k / 4)
				0: e = k[1] | k[0];
				1: e = !(k[1] & k[0]);
				default: e = !(k[1] & !k[0]);
			endcase
			chk("cutoff", 32'(output_cutoff), 32'(e));
			chk("permit", 32'(run_permit), 32'(!e));
			chk("interlock", 32'(panel_interlock), 32'(e));
		end
		cfg(8'h00, CUT_NO, 4'h0, 1'b0);
	endtask : t_cut
	task automatic t_run;
		sel3(FN_LOW, FN_MID, FN_CUT);
		slow <= 1'b1;
		want <= 5'h01;
		wt(8);
		chk("fwd", 32'(fwd_run), 32'h0000_0001);
		motor_running <= 1'b1;
		want <= 5'h11;
		wt(8);
		chk("coast", {30'h0000_0000, coast_stop, decel_stop}, 32'h0000_0002);
		chk("fwd", 32'(fwd_run), 32'h0000_0000);
		want <= 5'h00;
		wt(8);
		chk("decel", {30'h0000_0000, coast_stop, decel_stop}, 32'h0000_0001);
		motor_running <= 1'b0;
		want <= 5'h10;
		wt(8);
		want <= 5'h11;
		wt(8);
		chk("refused", 32'(fwd_run), 32'h0000_0000);
		want <= 5'h02;
		wt(8);
		chk("rev", 32'(rev_run), 32'h0000_0001);
		slow <= 1'b0;
		want <= 5'h00;
	endtask : t_run
	task automatic t_vf;
		sel3(FN_VF, FN_MID, FN_HIGH);
		want <= 5'h04;
		wt(14);
		chk("vf", {30'h0000_0000, vf_control, second_set_select}, 32'h0000_0003);
		motor_running <= 1'b1;
		want <= 5'h00;
		wt(14);
		chk("vf held", {30'h0000_0000, vf_control, second_set_select}, 32'h0000_0002);
		motor_running <= 1'b0;
		wt(14);
		chk("vf off", {30'h0000_0000, vf_control, second_set_select}, 32'h0000_0000);
	endtask : t_vf
	// Main sequence; ready lines stay high so every answer is taken at once
	initial begin
		aresetn = 1'b0;
		s_axi_awvalid = 1'b0;
		s_axi_wvalid = 1'b0;
		s_axi_arvalid = 1'b0;
		s_axi_bready = 1'b1;
		s_axi_rready = 1'b1;
		s_axi_awaddr = 8'h00;
		s_axi_araddr = 8'h00;
		s_axi_wdata = 32'h0000_0000;
		s_axi_wstrb = 4'hF;
		motor_running = 1'b0;
		slow = 1'b0;
		want = 5'h00;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		t_reset;
		t_codes;
		t_speed;
		t_prio;
		t_cut;
		t_run;
		t_vf;
		finish_test;
	end
	// Watchdog well beyond the expected thousand or so cycles
	initial begin
		repeat (20000) @(posedge aclk);
		n_mismatch++;
		finish_test;
	end
endmodule : tb
`default_nettype wire
